// ===== src/step_seq_pkg.sv
`default_nettype none

package step_seq_pkg;

    // ********************************
    // Bus geometry and register map
    // ********************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [ADDR_W-1:0] SOURCE_CFG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] LOGIC_CFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] RUN_CTRL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
    localparam logic [DATA_W-1:0] SOURCE_CFG_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] LOGIC_CFG_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RUN_CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************
    // Field positions
    // ********************************
    localparam int SRC_W = 4;
    localparam int RESET_SRC_LSB = 0;
    localparam int PAUSE_SRC_LSB = 4;
    localparam int OPER1_SRC_LSB = 8;
    localparam int OPER2_SRC_LSB = 12;
    localparam int OPER3_SRC_LSB = 16;
    localparam int COMB_W = 2;
    localparam int COMB1_LSB = 0;
    localparam int COMB2_LSB = 2;
    localparam int FORCE_W = 4;
    localparam int FORCE_LSB = 4;
    localparam int RUN_BIT = 0;
    localparam int ST_STEP_LSB = 0;
    localparam int ST_PAUSE_BIT = 4;
    localparam int ST_RUN_BIT = 5;
    localparam int ST_LOGIC_BIT = 6;
    localparam int ST_FREEZE_BIT = 7;

    // ********************************
    // Selector codes
    // ********************************
    localparam int NUM_LINES = 5;
    localparam int NUM_OPERANDS = 3;
    localparam logic [SRC_W-1:0] SRC_NONE = 4'h0;
    localparam logic [SRC_W-1:0] RESET_ONE_SHOT = 4'h6;
    localparam logic [SRC_W-1:0] PAUSE_ALWAYS = 4'h6;
    localparam logic [FORCE_W-1:0] FORCE_MIN = 4'h1;
    localparam logic [FORCE_W-1:0] FORCE_MAX = 4'h8;

    typedef enum logic [1:0] {
        COMB_PASS = 2'h0,
        COMB_AND = 2'h1,
        COMB_OR = 2'h2,
        COMB_XOR = 2'h3
    } comb_op_type;

    typedef enum logic [2:0] {
        STEP_1 = 3'h0,
        STEP_2 = 3'h1,
        STEP_3 = 3'h3,
        STEP_4 = 3'h2,
        STEP_5 = 3'h6,
        STEP_6 = 3'h7,
        STEP_7 = 3'h5,
        STEP_8 = 3'h4
    } step_type;

    // Signed selector: +k line k true, -k line k inverted, else false
    function automatic logic src_level(input logic [SRC_W-1:0] sel, input logic [NUM_LINES-1:0] lines);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_LINES; k++) begin
            if (sel == SRC_W'(k + 1)) begin
                r = lines[k];
            end
            if (sel == SRC_W'(-(k + 1))) begin
                r = ~lines[k];
            end
        end
        return r;
    endfunction

    function automatic logic comb_apply(input logic [COMB_W-1:0] op, input logic a, input logic b);
        logic r;
        case (comb_op_type'(op))
            COMB_AND: r = a & b;
            COMB_OR: r = a | b;
            COMB_XOR: r = a ^ b;
            default: r = a;
        endcase
        return r;
    endfunction

    function automatic step_type step_from_index(input logic [2:0] idx);
        step_type s;
        case (idx)
            3'h0: s = STEP_1;
            3'h1: s = STEP_2;
            3'h2: s = STEP_3;
            3'h3: s = STEP_4;
            3'h4: s = STEP_5;
            3'h5: s = STEP_6;
            3'h6: s = STEP_7;
            default: s = STEP_8;
        endcase
        return s;
    endfunction

endpackage

`default_nettype wire

// ===== src/operand_chain.sv
`timescale 1ns/1ps
`default_nettype none

module operand_chain (
    input wire logic [step_seq_pkg::NUM_OPERANDS*step_seq_pkg::SRC_W-1:0] operand_sources,
    input wire logic [step_seq_pkg::COMB_W-1:0] first_combine_operator,
    input wire logic [step_seq_pkg::COMB_W-1:0] second_combine_operator,
    input wire logic [step_seq_pkg::NUM_LINES-1:0] lines,
    output logic result
);
    import step_seq_pkg::*;

    logic [NUM_OPERANDS-1:0] operand;
    logic first_result;

    // ********************************
    // Operand selection
    // ********************************
    genvar g;
    generate
        for (g = 0; g < NUM_OPERANDS; g++) begin : g_operand
            assign operand[g] = src_level(operand_sources[g*SRC_W +: SRC_W], lines);
        end
    endgenerate

    // ********************************
    // Combine chain
    // ********************************
    always_comb begin
        first_result = comb_apply(first_combine_operator, operand[0], operand[1]);
        result = comb_apply(second_combine_operator, first_result, operand[2]);
    end

endmodule

`default_nettype wire

// ===== src/step_sequencer_control.sv
// Functional notes
// - Reset source: -5..-1 inverted, 0 none, 1..5 lines
// - Reset returns step 1, clears timers, outputs
// - Reset honoured only while sequencing stopped
// - Reset source 6: one reset, then 0
// - Pause source 6 holds pause always
// - Force values 1..8 select same step
// - Force acts only while paused
// - Operand source: inverted, false, or line
// - First operator combines operands 1 and 2
// - Operator: 0 pass, 1 AND, 2 OR, 3 XOR
// - Pause freezes timers, outputs; only force moves (code: a reset while stopped still returns step 1)
// - Second operator combines third operand, first result
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module step_sequencer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [step_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [step_seq_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [step_seq_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [step_seq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [step_seq_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic input_line_1,
    input wire logic input_line_2,
    input wire logic input_line_3,
    input wire logic input_line_4,
    input wire logic input_line_5,
    input wire logic transition_valid,
    input wire logic [2:0] transition_target,
    output logic [3:0] current_step_indicator,
    output logic clear_timers_outputs,
    output logic freeze_timers_outputs,
    output logic logic_result,
    output logic sequencing_running
);
    import step_seq_pkg::*;

    // ********************************
    // Input line synchroniser
    // ********************************
    logic [NUM_LINES-1:0] lines_raw;
    logic [NUM_LINES-1:0] sync1_r;
    logic [NUM_LINES-1:0] lines_r;

    assign lines_raw = {input_line_5, input_line_4, input_line_3, input_line_2, input_line_1};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            lines_r <= '0;
        end else begin
            sync1_r <= lines_raw;
            lines_r <= sync1_r;
        end
    end

    // ********************************
    // Bus write channel
    // ********************************
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic aw_held_r, aw_held_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [STRB_W-1:0] wstrb_r, wstrb_nxt;
    logic w_held_r, w_held_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic wr_fire;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

    always_comb begin
        awaddr_nxt = awaddr_r;
        aw_held_nxt = aw_held_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        w_held_nxt = w_held_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_nxt = s_axi_awaddr;
            aw_held_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
            w_held_nxt = 1'b1;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            case (awaddr_r)
                SOURCE_CFG_OFS, LOGIC_CFG_OFS, RUN_CTRL_OFS, STATUS_OFS: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= '0;
            aw_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            awaddr_r <= awaddr_nxt;
            aw_held_r <= aw_held_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            w_held_r <= w_held_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ********************************
    // Configuration registers
    // ********************************
    logic [DATA_W-1:0] source_cfg_r, source_cfg_nxt;
    logic [DATA_W-1:0] logic_cfg_r, logic_cfg_nxt;
    logic [DATA_W-1:0] run_ctrl_r, run_ctrl_nxt;
    logic [DATA_W-1:0] wr_merged;
    logic [SRC_W-1:0] reset_src;
    logic [SRC_W-1:0] pause_src;
    logic [FORCE_W-1:0] force_sel;

    assign reset_src = source_cfg_r[RESET_SRC_LSB +: SRC_W];
    assign pause_src = source_cfg_r[PAUSE_SRC_LSB +: SRC_W];
    assign force_sel = logic_cfg_r[FORCE_LSB +: FORCE_W];

    always_comb begin
        source_cfg_nxt = source_cfg_r;
        logic_cfg_nxt = logic_cfg_r;
        run_ctrl_nxt = run_ctrl_r;
        wr_merged = '0;
        if (reset_src == RESET_ONE_SHOT) begin
            source_cfg_nxt[RESET_SRC_LSB +: SRC_W] = SRC_NONE;
        end
        if (wr_fire) begin
            case (awaddr_r)
                SOURCE_CFG_OFS: wr_merged = source_cfg_r;
                LOGIC_CFG_OFS: wr_merged = logic_cfg_r;
                RUN_CTRL_OFS: wr_merged = run_ctrl_r;
                default: wr_merged = '0;
            endcase
            for (int b = 0; b < STRB_W; b++) begin
                if (wstrb_r[b]) begin
                    wr_merged[b*8 +: 8] = wdata_r[b*8 +: 8];
                end
            end
            case (awaddr_r)
                SOURCE_CFG_OFS: source_cfg_nxt = wr_merged;
                LOGIC_CFG_OFS: logic_cfg_nxt = wr_merged;
                RUN_CTRL_OFS: run_ctrl_nxt = wr_merged;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_cfg_r <= SOURCE_CFG_RST;
            logic_cfg_r <= LOGIC_CFG_RST;
            run_ctrl_r <= RUN_CTRL_RST;
        end else begin
            source_cfg_r <= source_cfg_nxt;
            logic_cfg_r <= logic_cfg_nxt;
            run_ctrl_r <= run_ctrl_nxt;
        end
    end

    // ********************************
    // Logic condition
    // ********************************
    logic logic_comb;
    logic logic_result_r;

    operand_chain u_operand_chain (
        .operand_sources(source_cfg_r[OPER1_SRC_LSB +: NUM_OPERANDS*SRC_W]),
        .first_combine_operator(logic_cfg_r[COMB1_LSB +: COMB_W]),
        .second_combine_operator(logic_cfg_r[COMB2_LSB +: COMB_W]),
        .lines(lines_r),
        .result(logic_comb)
    );

    // ********************************
    // Step control
    // ********************************
    step_type step_r, step_nxt;
    logic [3:0] indicator_r, indicator_nxt;
    logic clear_r, clear_nxt;
    logic freeze_r;
    logic pause_active;
    logic reset_req;
    logic running;

    assign running = run_ctrl_r[RUN_BIT];

    always_comb begin
        pause_active = (pause_src == PAUSE_ALWAYS) | src_level(pause_src, lines_r);
        reset_req = (reset_src == RESET_ONE_SHOT) | src_level(reset_src, lines_r);
        step_nxt = step_r;
        clear_nxt = 1'b0;
        if (reset_req && !running) begin
            step_nxt = STEP_1;
            clear_nxt = 1'b1;
        end else if (pause_active) begin
            if (force_sel >= FORCE_MIN && force_sel <= FORCE_MAX) begin
                step_nxt = step_from_index(3'(force_sel - FORCE_MIN));
            end
        end else if (running && transition_valid) begin
            step_nxt = step_from_index(transition_target);
        end
        case (step_nxt)
            STEP_1: indicator_nxt = 4'h1;
            STEP_2: indicator_nxt = 4'h2;
            STEP_3: indicator_nxt = 4'h3;
            STEP_4: indicator_nxt = 4'h4;
            STEP_5: indicator_nxt = 4'h5;
            STEP_6: indicator_nxt = 4'h6;
            STEP_7: indicator_nxt = 4'h7;
            default: indicator_nxt = 4'h8;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_r <= STEP_1;
            indicator_r <= 4'h1;
            clear_r <= 1'b0;
            freeze_r <= 1'b0;
            logic_result_r <= 1'b0;
        end else begin
            step_r <= step_nxt;
            indicator_r <= indicator_nxt;
            clear_r <= clear_nxt;
            freeze_r <= pause_active;
            logic_result_r <= logic_comb;
        end
    end

    assign current_step_indicator = indicator_r;
    assign clear_timers_outputs = clear_r;
    assign freeze_timers_outputs = freeze_r;
    assign logic_result = logic_result_r;
    assign sequencing_running = run_ctrl_r[RUN_BIT];

    // ********************************
    // Bus read channel
    // ********************************
    logic rvalid_r, rvalid_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [DATA_W-1:0] status_word;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        status_word = '0;
        status_word[ST_STEP_LSB +: 4] = indicator_r;
        status_word[ST_PAUSE_BIT] = pause_active;
        status_word[ST_RUN_BIT] = running;
        status_word[ST_LOGIC_BIT] = logic_result_r;
        status_word[ST_FREEZE_BIT] = freeze_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr)
                SOURCE_CFG_OFS: rdata_nxt = source_cfg_r;
                LOGIC_CFG_OFS: rdata_nxt = logic_cfg_r;
                RUN_CTRL_OFS: rdata_nxt = run_ctrl_r;
                STATUS_OFS: rdata_nxt = status_word;
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== tb/step_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module step_seq_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic transition_valid,
    input wire logic [2:0] transition_target,
    input wire logic [3:0] current_step_indicator,
    input wire logic clear_timers_outputs,
    input wire logic freeze_timers_outputs,
    input wire logic sequencing_running
);
    import step_seq_pkg::*;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****
    // Step control
    // ****
    step_range_a: assert property (current_step_indicator inside {[4'h1:4'h8]})
        else $error("step indicator out of range");
    clear_to_first_a: assert property (clear_timers_outputs |-> current_step_indicator == 4'h1)
        else $error("clear pulse without first step");
    clear_when_stopped_a: assert property (clear_timers_outputs |-> !$past(sequencing_running))
        else $error("clear pulse while running");
    step_move_a: assert property ($changed(current_step_indicator) && !freeze_timers_outputs
        && !clear_timers_outputs |-> $past(transition_valid) && $past(sequencing_running)
        && current_step_indicator == {1'b0, $past(transition_target)} + 4'h1)
        else $error("step moved without a transition");

    // ****
    // Register bus
    // ****
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rdata_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");

    cover property (clear_timers_outputs);
    cover property ($rose(freeze_timers_outputs));
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind step_sequencer_control step_seq_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .transition_valid(transition_valid), .transition_target(transition_target),
    .current_step_indicator(current_step_indicator), .clear_timers_outputs(clear_timers_outputs),
    .freeze_timers_outputs(freeze_timers_outputs), .sequencing_running(sequencing_running));

`default_nettype wire

// ===== tb/input_terminals.sv
`timescale 1ns/1ps
`default_nettype none

module input_terminals (
    input wire logic aclk,
    input wire logic [4:0] level_req,
    output logic input_line_1,
    output logic input_line_2,
    output logic input_line_3,
    output logic input_line_4,
    output logic input_line_5
);
    logic [4:0] level_r = 5'h00;

    // Terminals switch out of phase with the clock
    always @(posedge aclk) begin
        #7 level_r = level_req;
    end

    assign {input_line_5, input_line_4, input_line_3, input_line_2, input_line_1} = level_r;
endmodule

`default_nettype wire

// ===== tb/tb_step_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_step_sequencer_control;
    import step_seq_pkg::*;

    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic tv, clr, frz, lres, run;
    logic [2:0] tt;
    logic [3:0] step;
    logic [4:0] lines_req, idle;
    wire logic [4:0] ln;
    int miscompares, n_tests, clear_seen, base;

    step_sequencer_control dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .input_line_1(ln[0]), .input_line_2(ln[1]), .input_line_3(ln[2]),
        .input_line_4(ln[3]), .input_line_5(ln[4]), .transition_valid(tv), .transition_target(tt),
        .current_step_indicator(step), .clear_timers_outputs(clr), .freeze_timers_outputs(frz),
        .logic_result(lres), .sequencing_running(run));

    input_terminals term_u (.aclk(aclk), .level_req(lines_req), .input_line_1(ln[0]), .input_line_2(ln[1]),
        .input_line_3(ln[2]), .input_line_4(ln[3]), .input_line_5(ln[4]));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    always @(negedge aclk) begin
        if (clr === 1'b1) clear_seen++;
    end

    // ****
    // Helpers
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] r_s;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            #1;
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            r_s = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
        end
        check({30'h0, r_s}, {30'h0, er});
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed, input logic [1:0] er);
        logic ar_hs, r_hs;
        logic [DATA_W-1:0] d_s;
        logic [1:0] r_s;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            #1;
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            d_s = rdata;
            r_s = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) rready <= 1'b0;
        end
        check(d_s, ed);
        check({30'h0, r_s}, {30'h0, er});
    endtask

    task automatic step_to(input logic [2:0] t);
        @(posedge aclk);
        tv <= 1'b1;
        tt <= t;
        @(posedge aclk);
        tv <= 1'b0;
    endtask

    task automatic set_lines(input logic [4:0] v);
        @(posedge aclk);
        lines_req <= v;
        cyc(8);
    endtask

    function automatic logic op_f(input logic [1:0] o, input logic a, input logic b);
        case (o)
            2'h1: op_f = a & b;
            2'h2: op_f = a | b;
            2'h3: op_f = a ^ b;
            default: op_f = a;
        endcase
    endfunction

    initial begin
        repeat (30000) @(posedge aclk);
        miscompares++;
        end_sim();
    end

    // ****
    // Tests
    // ****
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, tv} = 7'h00;
        {awaddr, araddr, wdata, tt, lines_req} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SOURCE_CFG_OFS, SOURCE_CFG_RST, RESP_OKAY);
        rd(LOGIC_CFG_OFS, LOGIC_CFG_RST, RESP_OKAY);
        rd(RUN_CTRL_OFS, RUN_CTRL_RST, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        rd(STATUS_OFS, 32'h1 << ST_STEP_LSB, RESP_OKAY);
        $display("Test registers done");

        wr(SOURCE_CFG_OFS, 32'h000D_2F00, RESP_OKAY);
        for (int p = 0; p < 8; p++) begin
            set_lines(5'(p));
            for (int o = 0; o < 16; o++) begin
                wr(LOGIC_CFG_OFS, 32'(o), RESP_OKAY);
                cyc(2);
                check({31'h0, lres}, {31'h0, op_f(2'(o >> 2), op_f(2'(o), ~p[0], p[1]), ~p[2])});
            end
        end
        wr(SOURCE_CFG_OFS, 32'h0, RESP_OKAY);
        wr(LOGIC_CFG_OFS, 32'h0, RESP_OKAY);
        cyc(2);
        check({31'h0, lres}, 32'h0);
        $display("Test logic done");

        for (int k = 1; k <= 5; k++) begin
            for (int inv = 0; inv < 2; inv++) begin
                idle = inv ? 5'h1F : 5'h00;
                set_lines(idle);
                wr(SOURCE_CFG_OFS, inv ? 32'(4'(-k)) : 32'(k), RESP_OKAY);
                wr(RUN_CTRL_OFS, 32'h1, RESP_OKAY);
                step_to(3'(k + 1));
                base = clear_seen;
                set_lines(idle ^ (5'h01 << (k - 1)));
                check({28'h0, step}, 32'(k + 2));
                check(32'(clear_seen - base), 32'h0);
                wr(RUN_CTRL_OFS, 32'h0, RESP_OKAY);
                cyc(3);
                check({28'h0, step}, 32'h1);
                check(32'(clear_seen > base), 32'h1);
            end
        end
        $display("Test reset sources done");

        wr(SOURCE_CFG_OFS, 32'h0, RESP_OKAY);
        wr(RUN_CTRL_OFS, 32'h1, RESP_OKAY);
        step_to(3'h2);
        wr(RUN_CTRL_OFS, 32'h0, RESP_OKAY);
        wr(SOURCE_CFG_OFS, 32'(RESET_ONE_SHOT), RESP_OKAY);
        cyc(3);
        check({28'h0, step}, 32'h1);
        rd(SOURCE_CFG_OFS, 32'h0, RESP_OKAY);
        $display("Test one-shot reset done");

        wr(SOURCE_CFG_OFS, 32'(PAUSE_ALWAYS) << PAUSE_SRC_LSB, RESP_OKAY);
        wr(RUN_CTRL_OFS, 32'h1, RESP_OKAY);
        @(posedge aclk);
        tv <= 1'b1;
        tt <= 3'h0;
        for (int f = 1; f <= 8; f++) begin
            wr(LOGIC_CFG_OFS, 32'(f) << FORCE_LSB, RESP_OKAY);
            cyc(2);
            check({28'h0, step}, 32'(f));
            check({31'h0, frz}, 32'h1);
        end
        rd(STATUS_OFS, 32'h8 | 32'(1 << ST_PAUSE_BIT | 1 << ST_RUN_BIT | 1 << ST_FREEZE_BIT), RESP_OKAY);
        check({31'h0, run}, 32'h1);
        @(posedge aclk);
        tv <= 1'b0;
        wr(SOURCE_CFG_OFS, 32'h0, RESP_OKAY);
        wr(LOGIC_CFG_OFS, 32'h2 << FORCE_LSB, RESP_OKAY);
        cyc(3);
        check({28'h0, step}, 32'h8);
        check({31'h0, frz}, 32'h0);
        wr(SOURCE_CFG_OFS, 32'h1 << PAUSE_SRC_LSB, RESP_OKAY);
        cyc(3);
        check({28'h0, step}, 32'h2);
        check({31'h0, frz}, 32'h1);
        set_lines(5'h0E);
        check({31'h0, frz}, 32'h0);
        check({28'h0, step}, 32'h2);
        wr(RUN_CTRL_OFS, 32'h0, RESP_OKAY);
        $display("Test pause and force done");
        end_sim();
    end
endmodule

`default_nettype wire
